// [srt_timer.sv]
// file: sixteen bit rollover timer with avalon-mm register slave
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/100ps

// Contract
// [RULE_01] select bit one counts system clock ticks, zero counts instruction ticks.
// [RULE_02] divide field 00..11 divides selected ticks by 1, 2, 4, 8.
// [RULE_03] prescale counter is hidden; any count byte write clears it.
// [RULE_04] sixteen bit count goes upward and wraps from ffff to 0000.
// [RULE_05] every wrap sets the rollover flag in the peripheral flags.
// [RULE_06] interrupt only with count on, rollover, peripheral, global enables set; the irq output needs only irq_status and irq_enable.
// [RULE_07] rollover flag stays set until software clears it.
// [RULE_08] software should clear count and flag before enabling the interrupt.
// [RULE_09] control bits 7-6 and 3-2 read zero and ignore writes.
// [RULE_10] no counting during sleep; rollover never wakes the device.
// [RULE_11] counting happens only while count on is set.
// [RULE_12] a count byte write replaces that byte of the live count.
// [RULE_13] with count on clear, count holds and flag is not set.
// [RULE_14] control register resets to zero: stopped, instruction clock, divide one.
module srt_timer (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [1:0]  avs_response,
    // device state
    input  wire logic        sleep_req,
    // interrupts
    output logic             rollover_irq,
    output logic             irq
);

    // ************************************************************
    // state
    // ************************************************************
    srt_pkg::srt_control_t ctl, next_ctl;
    logic [7:0]  irq_control, next_irq_control;
    logic [7:0]  periph_enables, next_periph_enables;
    logic        rollover_flag, next_rollover_flag;
    logic [15:0] count, next_count;
    logic [2:0]  prescale, next_prescale;
    logic [1:0]  insn_phase, next_insn_phase;
    logic        irq_status, next_irq_status;
    logic        irq_enable, next_irq_enable;
    logic        asleep, next_asleep;
    logic        ack, next_ack;
    logic [31:0] rdata, next_rdata;
    logic        err, next_err;
    logic        tick, pre_done, inc, wrap, wr, rd, hit;
    logic [2:0]  div_last;

    // ************************************************************
    // bus decode: one wait cycle, answer on the second edge
    // ************************************************************
    assign wr  = avs_write & ~ack & avs_byteenable[0];
    assign rd  = avs_read & ~ack;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign avs_readdata    = rdata;
    assign avs_response    = err ? 2'h2 : 2'h0;

    always_comb begin
        hit = 1'b1;
        next_rdata = 32'h0;
        case (avs_address)
            6'(srt_pkg::ADDR_TIMER_CONTROL):
                next_rdata[7:0] = {2'h0, ctl.input_divide_select, 2'h0,
                                   ctl.clock_source_select,
                                   ctl.count_on}; // RULE_09
            6'(srt_pkg::ADDR_IRQ_CONTROL):    next_rdata[7:0] = irq_control;
            6'(srt_pkg::ADDR_PERIPH_ENABLES): next_rdata[7:0] = periph_enables;
            6'(srt_pkg::ADDR_PERIPH_FLAGS):
                next_rdata[srt_pkg::POS_ROLLOVER] = rollover_flag;
            srt_pkg::ADDR_COUNT_HIGH: next_rdata[7:0] = count[15:8];
            srt_pkg::ADDR_COUNT_LOW:  next_rdata[7:0] = count[7:0];
            srt_pkg::ADDR_IRQ_STATUS: next_rdata[0] = irq_status;
            srt_pkg::ADDR_IRQ_CLEAR:  next_rdata = 32'h0;
            srt_pkg::ADDR_IRQ_ENABLE: next_rdata[0] = irq_enable;
            srt_pkg::ADDR_SLEEP:      next_rdata[0] = asleep;
            default:                  hit = 1'b0;
        endcase
        if (!rd) begin
            next_rdata = rdata;
        end
        next_ack = (avs_read | avs_write) & ~ack;
        next_err = (avs_read | avs_write) & ~ack ? ~hit : err;
    end

    // ************************************************************
    // clock select and hidden prescaler
    // ************************************************************
    always_comb begin
        next_insn_phase = insn_phase + 2'h1;
        if (insn_phase == srt_pkg::INSN_LAST) begin
            next_insn_phase = 2'h0;
        end
        tick = ctl.clock_source_select ? 1'b1
                                       : (insn_phase == srt_pkg::INSN_LAST); // RULE_01
        case (srt_pkg::srt_divide_t'(ctl.input_divide_select)) // RULE_02
            srt_pkg::SRT_DIV_1: div_last = 3'h0;
            srt_pkg::SRT_DIV_2: div_last = 3'h1;
            srt_pkg::SRT_DIV_4: div_last = 3'h3;
            srt_pkg::SRT_DIV_8: div_last = 3'h7;
            default:            div_last = 3'h0;
        endcase
        pre_done = (prescale >= div_last);
        inc = ctl.count_on & ~asleep & tick & pre_done; // RULE_10 RULE_11 RULE_13
        wrap = inc & (count == srt_pkg::COUNT_MAX);
        next_prescale = prescale;
        if (ctl.count_on && !asleep && tick) begin
            next_prescale = pre_done ? 3'h0 : prescale + 3'h1;
        end
        if (wr && (avs_address == srt_pkg::ADDR_COUNT_HIGH
                || avs_address == srt_pkg::ADDR_COUNT_LOW)) begin
            next_prescale = 3'h0; // RULE_03
        end
    end

    // ************************************************************
    // count and registers
    // ************************************************************
    always_comb begin
        next_ctl = ctl;
        next_irq_control = irq_control;
        next_periph_enables = periph_enables;
        next_irq_enable = irq_enable;
        next_asleep = sleep_req;
        next_count = inc ? count + 16'h1 : count; // RULE_04
        next_rollover_flag = rollover_flag;
        next_irq_status = irq_status;
        if (wr) begin
            case (avs_address)
                6'(srt_pkg::ADDR_TIMER_CONTROL):
                    next_ctl = {avs_writedata[5:4], avs_writedata[1:0]}; // RULE_09
                6'(srt_pkg::ADDR_IRQ_CONTROL):
                    next_irq_control = avs_writedata[7:0];
                6'(srt_pkg::ADDR_PERIPH_ENABLES):
                    next_periph_enables = avs_writedata[7:0];
                6'(srt_pkg::ADDR_PERIPH_FLAGS):
                    next_rollover_flag = avs_writedata[srt_pkg::POS_ROLLOVER]; // RULE_07
                srt_pkg::ADDR_COUNT_HIGH:
                    next_count[15:8] = avs_writedata[7:0]; // RULE_12
                srt_pkg::ADDR_COUNT_LOW:
                    next_count[7:0] = avs_writedata[7:0]; // RULE_12
                srt_pkg::ADDR_IRQ_CLEAR:
                    if (avs_writedata[0]) next_irq_status = 1'b0;
                srt_pkg::ADDR_IRQ_ENABLE:
                    next_irq_enable = avs_writedata[0];
                default: ;
            endcase
        end
        if (wrap) begin
            next_rollover_flag = 1'b1; // RULE_05
            next_irq_status = 1'b1;
        end
    end

    assign rollover_irq = ctl.count_on & rollover_flag
        & periph_enables[srt_pkg::POS_ROLLOVER]
        & irq_control[srt_pkg::POS_PERIPH_IRQ_EN]
        & irq_control[srt_pkg::POS_GLOBAL_IRQ_EN]; // RULE_06
    assign irq = irq_status & irq_enable;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl            <= srt_pkg::srt_control_t'(4'h0); // RULE_14
            irq_control    <= srt_pkg::RESET_BYTE;
            periph_enables <= srt_pkg::RESET_BYTE;
            rollover_flag  <= 1'b0;
            count          <= 16'h0000;
            prescale       <= 3'h0;
            insn_phase     <= 2'h0;
            irq_status     <= 1'b0;
            irq_enable     <= 1'b0;
            asleep         <= 1'b0;
            ack            <= 1'b0;
            rdata          <= 32'h0;
            err            <= 1'b0;
        end else begin
            ctl            <= next_ctl;
            irq_control    <= next_irq_control;
            periph_enables <= next_periph_enables;
            rollover_flag  <= next_rollover_flag;
            count          <= next_count;
            prescale       <= next_prescale;
            insn_phase     <= next_insn_phase;
            irq_status     <= next_irq_status;
            irq_enable     <= next_irq_enable;
            asleep         <= next_asleep;
            ack            <= next_ack;
            rdata          <= next_rdata;
            err            <= next_err;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_wrap_to_zero: assert property (@(posedge clk) disable iff (rst) // RULE_04
        wrap && !wr |=> count == 16'h0000)
        else $error("count did not wrap to zero");
    a_wrap_sets_flag: assert property (@(posedge clk) disable iff (rst) // RULE_05
        wrap |=> rollover_flag)
        else $error("wrap did not set rollover flag");
    a_flag_sticky: assert property (@(posedge clk) disable iff (rst) // RULE_07
        rollover_flag && !(wr && avs_address == 6'(srt_pkg::ADDR_PERIPH_FLAGS))
        |=> rollover_flag)
        else $error("rollover flag dropped by itself");
    a_stopped_holds: assert property (@(posedge clk) disable iff (rst) // RULE_13
        !ctl.count_on && !wr |=> count == $past(count))
        else $error("count moved while stopped");
    a_sleep_holds: assert property (@(posedge clk) disable iff (rst) // RULE_10
        asleep && !wr |=> $stable(count))
        else $error("count moved during sleep");
    a_irq_gate: assert property (@(posedge clk) disable iff (rst) // RULE_06
        rollover_irq |-> ctl.count_on && irq_control[7] && irq_control[6]
        && periph_enables[0] && rollover_flag)
        else $error("rollover interrupt without all enables");
    a_fast_div1: assert property (@(posedge clk) disable iff (rst) // RULE_01
        ctl.count_on && ctl.clock_source_select
        && ctl.input_divide_select == 2'h0 && !asleep && !wr
        && $stable(ctl) |=> count == $past(count) + 16'h1)
        else $error("system clock divide one did not count");
    a_prescale_clear: assert property (@(posedge clk) disable iff (rst) // RULE_03
        wr && avs_address == srt_pkg::ADDR_COUNT_LOW |=> prescale == 3'h0)
        else $error("prescaler not cleared by count write");
    a_ctl_reserved: assert property (@(posedge clk) disable iff (rst) // RULE_09
        ack && avs_read && avs_address == 6'(srt_pkg::ADDR_TIMER_CONTROL)
        |-> (avs_readdata & ~32'(srt_pkg::MASK_TIMER_CONTROL)) == 32'h0)
        else $error("reserved control bits not zero");
    a_byte_write: assert property (@(posedge clk) disable iff (rst) // RULE_12
        wr && avs_address == srt_pkg::ADDR_COUNT_HIGH
        |=> count[15:8] == $past(avs_writedata[7:0]))
        else $error("high byte write not applied");

    // ************************************************************
    // count, prescale, flag, status, control reset and bus handshake checks
    // ************************************************************
    a_low_byte: assert property (@(posedge clk) disable iff (rst) // RULE_12
        wr && avs_address == srt_pkg::ADDR_COUNT_LOW
        |=> count[7:0] == $past(avs_writedata[7:0]))
        else $error("low byte write not applied");
    a_prescale_high: assert property (@(posedge clk) disable iff (rst) // RULE_03
        wr && avs_address == srt_pkg::ADDR_COUNT_HIGH |=> prescale == 3'h0)
        else $error("prescaler not cleared by high byte write");
    a_step_one: assert property (@(posedge clk) disable iff (rst) // RULE_04
        inc && !wr |=> count == $past(count) + 16'h1)
        else $error("count did not step by one");
    a_insn_tick: assert property (@(posedge clk) disable iff (rst) // RULE_01
        inc && !ctl.clock_source_select |-> insn_phase == srt_pkg::INSN_LAST)
        else $error("instruction clock step off its tick");
    a_div2_gap: assert property (@(posedge clk) disable iff (rst) // RULE_02
        inc && ctl.input_divide_select == 2'h1 && !wr |=> !inc)
        else $error("divide by two stepped twice in a row");
    a_div8_gap: assert property (@(posedge clk) disable iff (rst) // RULE_02
        inc && ctl.input_divide_select == 2'h3 && !wr |=> !inc)
        else $error("divide by eight stepped twice in a row");
    a_stop_no_flag: assert property (@(posedge clk) disable iff (rst) // RULE_13
        !ctl.count_on && !rollover_flag && !wr |=> !rollover_flag)
        else $error("flag set while stopped");
    a_prescale_hold: assert property (@(posedge clk) disable iff (rst) // RULE_11
        !ctl.count_on && !wr |=> $stable(prescale))
        else $error("prescaler moved while stopped");
    a_sleep_prescale: assert property (@(posedge clk) disable iff (rst) // RULE_10
        asleep && !wr |=> $stable(prescale))
        else $error("prescaler moved during sleep");
    a_sleep_no_flag: assert property (@(posedge clk) disable iff (rst) // RULE_10
        asleep && !rollover_flag && !wr |=> !rollover_flag)
        else $error("flag set during sleep");
    a_flag_write: assert property (@(posedge clk) disable iff (rst) // RULE_07
        wr && avs_address == 6'(srt_pkg::ADDR_PERIPH_FLAGS) && !wrap
        |=> rollover_flag == $past(avs_writedata[srt_pkg::POS_ROLLOVER]))
        else $error("software flag write not applied");
    a_status_sticky: assert property (@(posedge clk) disable iff (rst) // RULE_07
        irq_status && !(wr && avs_address == srt_pkg::ADDR_IRQ_CLEAR)
        |=> irq_status)
        else $error("status dropped without a clear");
    a_status_wrap: assert property (@(posedge clk) disable iff (rst) // RULE_05
        wrap |=> irq_status)
        else $error("wrap did not set status");
    a_reset_ctl: assert property (@(posedge clk) // RULE_14
        $fell(rst) |-> ctl.count_on == 1'b0 && ctl.clock_source_select == 1'b0
        && ctl.input_divide_select == 2'h0)
        else $error("control not zero after reset");
    a_wait_once: assert property (@(posedge clk) disable iff (rst)
        (avs_read || avs_write) && !ack |=> ack)
        else $error("request not answered after one wait");
    a_ack_single: assert property (@(posedge clk) disable iff (rst)
        ack |=> !ack)
        else $error("answer held longer than one cycle");

    c_wrap: cover property (@(posedge clk) disable iff (rst) wrap);
    c_irq: cover property (@(posedge clk) disable iff (rst) rollover_irq);
    c_div8: cover property (@(posedge clk) disable iff (rst)
        inc && ctl.input_divide_select == 2'h3);
    c_err: cover property (@(posedge clk) disable iff (rst) err && ack);
    c_sleep: cover property (@(posedge clk) disable iff (rst)
        asleep && ctl.count_on);

endmodule : srt_timer

// [srt_pkg.sv]
// package: register map, field layout and timing constants of the timer
package srt_pkg;

    // ************************************************************
    // register indices and byte addresses
    // ************************************************************
    localparam logic [3:0] ADDR_TIMER_CONTROL   = 4'h0;
    localparam logic [3:0] ADDR_IRQ_CONTROL     = 4'h4;
    localparam logic [3:0] ADDR_PERIPH_ENABLES  = 4'h8;
    localparam logic [3:0] ADDR_PERIPH_FLAGS    = 4'hc;
    localparam int         ADDR_W               = 6;
    localparam logic [5:0] ADDR_COUNT_HIGH      = 6'h10;
    localparam logic [5:0] ADDR_COUNT_LOW       = 6'h14;
    localparam logic [5:0] ADDR_IRQ_STATUS      = 6'h18;
    localparam logic [5:0] ADDR_IRQ_CLEAR       = 6'h1c;
    localparam logic [5:0] ADDR_IRQ_ENABLE      = 6'h20;
    localparam logic [5:0] ADDR_SLEEP           = 6'h24;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int         POS_COUNT_ON         = 0;
    localparam int         POS_CLOCK_SOURCE     = 1;
    localparam int         POS_DIVIDE_LO        = 4;
    localparam logic [7:0] MASK_TIMER_CONTROL   = 8'h33;
    localparam int         POS_GLOBAL_IRQ_EN    = 7;
    localparam int         POS_PERIPH_IRQ_EN    = 6;
    localparam int         POS_ROLLOVER         = 0;
    localparam logic [7:0] RESET_TIMER_CONTROL  = 8'h00;
    localparam logic [7:0] RESET_BYTE           = 8'h00;
    localparam logic [15:0] COUNT_MAX           = 16'hffff;

    // ************************************************************
    // timing: instruction clock is the system clock divided by four
    // ************************************************************
    localparam int SYS_CLOCK_MHZ   = 8;
    localparam int INSN_CLOCK_MHZ  = 2;
    localparam int INSN_DIVIDE     = SYS_CLOCK_MHZ / INSN_CLOCK_MHZ;
    localparam logic [1:0] INSN_LAST = 2'(INSN_DIVIDE - 1);

    typedef struct packed {
        logic [1:0] input_divide_select;
        logic       clock_source_select;
        logic       count_on;
    } srt_control_t;

    typedef enum logic [1:0] {
        SRT_DIV_1 = 2'h0,
        SRT_DIV_2 = 2'h1,
        SRT_DIV_4 = 2'h2,
        SRT_DIV_8 = 2'h3
    } srt_divide_t;

endpackage : srt_pkg

// [srt_timer_tb_top.sv]
// testbench: register-level scenarios for the rollover timer
`timescale 1ns/100ps
module srt_timer_tb_top;
    // ************************************************************
    // signals
    // ************************************************************
    logic        clk, rst, avs_read, avs_write, sleep_req;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd_seen, q;
    logic [3:0]  avs_byteenable;
    logic [1:0]  avs_response, rsp_seen, rsp;
    logic        avs_waitrequest, rollover_irq, irq;
    logic        wr_seen, rirq_seen, irq_seen;
    int          n_mismatch, cmp_count, cyc;
    logic [7:0]  v1, v2;

    srt_timer dut_u (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .sleep_req(sleep_req),
        .rollover_irq(rollover_irq), .irq(irq));

    // ************************************************************
    // clock, reset, observation, timeout
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // settled values of the cycle before each rising edge
    always @(negedge clk) begin
        wr_seen   <= avs_waitrequest;
        rd_seen   <= avs_readdata;
        rsp_seen  <= avs_response;
        rirq_seen <= rollover_irq;
        irq_seen  <= irq;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [7:0] d);
        avs_address   <= a;
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (wr_seen !== 1'b0);
        q   = rd_seen;
        rsp = rsp_seen;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic rd_chk(input string what, input logic [5:0] a,
                          input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(what, q, {24'h0, exp});
    endtask : rd_chk

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset_and_map();
        logic [5:0] regs [8] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10,
                                 6'h14, 6'h18, 6'h20};
        foreach (regs[i]) rd_chk("reset value", regs[i], 8'h00);
        bus(1'b1, 6'h00, 8'hff);
        rd_chk("control unused bits", 6'h00, 8'h33);
        avs_byteenable <= 4'he;
        bus(1'b1, 6'h00, 8'h00);
        avs_byteenable <= 4'hf;
        rd_chk("lane zero off write", 6'h00, 8'h33);
        bus(1'b0, 6'h28, 8'h00);
        check("unmapped read", {rsp, q[7:0]}, {2'h2, 8'h00});
        bus(1'b1, 6'h00, 8'h00);
    endtask : t_reset_and_map

    task automatic t_hold_stopped();
        bus(1'b1, 6'h10, 8'hff);
        bus(1'b1, 6'h14, 8'hff);
        repeat (100) @(posedge clk);
        rd_chk("stopped count", 6'h14, 8'hff);
        rd_chk("stopped flag", 6'h0c, 8'h00);
    endtask : t_hold_stopped

    task automatic t_rates();
        int t;
        bus(1'b1, 6'h10, 8'h00);
        for (int s = 0; s < 2; s++) begin
            for (int dv = 0; dv < 4; dv++) begin
                t = (s == 1 ? 1 : 4) << dv;
                bus(1'b1, 6'h00, {2'h0, 2'(dv), 2'h0, 1'(s), 1'b1});
                bus(1'b0, 6'h14, 8'h00);
                v1 = q[7:0];
                repeat (64 * t) @(posedge clk);
                bus(1'b0, 6'h14, 8'h00);
                v2 = q[7:0] - v1;
                check("tick rate", 1'(v2 >= 63 && v2 <= 68), 1'b1);
            end
        end
        // prescaler restarts on the write: no step for seven ticks
        bus(1'b1, 6'h14, 8'h10);
        rd_chk("live byte write", 6'h14, 8'h10);
        bus(1'b1, 6'h00, 8'h00);
    endtask : t_rates

    task automatic t_wrap_irq();
        logic [5:0] a [4] = '{6'h04, 6'h04, 6'h08, 6'h00};
        logic [7:0] off [4] = '{8'h40, 8'h80, 8'h00, 8'h02};
        logic [7:0] on [4] = '{8'hc0, 8'hc0, 8'h01, 8'h03};
        bus(1'b1, 6'h0c, 8'h00);
        bus(1'b1, 6'h1c, 8'h01);
        bus(1'b1, 6'h10, 8'hff);
        bus(1'b1, 6'h14, 8'hff);
        bus(1'b1, 6'h08, 8'h01);
        bus(1'b1, 6'h04, 8'hc0);
        bus(1'b1, 6'h20, 8'h01);
        check("irq before wrap", {rirq_seen, irq_seen}, 2'b00);
        bus(1'b1, 6'h00, 8'h03);
        rd_chk("wrapped high", 6'h10, 8'h00);
        rd_chk("rollover flag", 6'h0c, 8'h01);
        rd_chk("sticky status", 6'h18, 8'h01);
        check("irq lines", {rirq_seen, irq_seen}, 2'b11);
        foreach (a[k]) begin
            bus(1'b1, a[k], off[k]);
            check("gated irq", rirq_seen, 1'b0);
            bus(1'b1, a[k], on[k]);
            check("ungated irq", rirq_seen, 1'b1);
        end
        repeat (200) @(posedge clk);
        rd_chk("flag persists", 6'h0c, 8'h01);
        bus(1'b1, 6'h20, 8'h00);
        check("masked irq", irq_seen, 1'b0);
        bus(1'b1, 6'h20, 8'h01);
        bus(1'b1, 6'h1c, 8'h01);
        check("cleared irq", irq_seen, 1'b0);
        rd_chk("status after clear", 6'h18, 8'h00);
        rd_chk("clear reads zero", 6'h1c, 8'h00);
        bus(1'b1, 6'h0c, 8'h00);
        check("flag cleared irq", rirq_seen, 1'b0);
    endtask : t_wrap_irq

    task automatic t_sleep();
        sleep_req <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, 6'h14, 8'h00);
        v1 = q[7:0];
        repeat (50) @(posedge clk);
        rd_chk("asleep count", 6'h14, v1);
        rd_chk("sleep state", 6'h24, 8'h01);
        sleep_req <= 1'b0;
        repeat (20) @(posedge clk);
        bus(1'b0, 6'h14, 8'h00);
        check("awake count", 1'(q[7:0] != v1), 1'b1);
    endtask : t_sleep

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        sleep_req = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset_and_map();
        t_hold_stopped();
        t_rates();
        t_wrap_irq();
        t_sleep();
        close_out();
    end
endmodule : srt_timer_tb_top
